// ==== channel_trigger_burst_control.v ====
// Per-channel trigger, burst and sync marker controller
`timescale 1ns/100ps
`include "trig_burst_defines.vh"
module channel_trigger_burst_control #(
  parameter [1:0] CHANNEL_INDEX = 2'h0
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Configuration
  input wire [2:0] mode,
  input wire [2:0] start_source,
  input wire [2:0] advance_source,
  input wire [1:0] func_class,
  input wire func_change,
  input wire [`COUNT_W-1:0] burst_count,
  input wire [`PERIOD_W-1:0] int_period_steps,
  input wire ext_polarity_pos,
  input wire [3:1] channel_installed,
  input wire output_on,
  input wire sync_set_on,
  input wire sync_set_off,
  // Asynchronous trigger pins
  input wire system_trigger,
  input wire manual_trigger_key,
  input wire ext_trigger,
  // Trigger inputs from other channels (same clock)
  input wire master_trigger_in,
  input wire ch2_trig_out,
  input wire ch3_trig_out,
  input wire ch4_trig_out,
  input wire prev_trig_out,
  // Playback engine status
  input wire [`ADDR_W-1:0] play_addr,
  input wire [`ADDR_W-1:0] last_active_addr,
  input wire cycle_end,
  input wire zero_cross,
  // Playback engine control
  output reg play_run,
  output reg play_restart,
  output reg advance_pulse,
  output reg sweep_step,
  output reg sweep_dir_up,
  // Trigger and marker outputs
  output reg master_trigger_out,
  output reg wave_complete,
  output reg count_complete,
  output reg sync_marker,
  output reg sync_enable,
  output reg burst_busy
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_DRAIN = 2'h2;

  // Synchronised pins
  wire sys_lvl, sys_rise, sys_fall;
  wire man_lvl, man_rise, man_fall;
  wire ext_lvl, ext_rise, ext_fall;
  wire int_tick;

  trig_sync sync_sys (
    .clk(clk), .rst_n(rst_n), .ce(ce), .async_in(system_trigger),
    .level(sys_lvl), .rise(sys_rise), .fall(sys_fall));
  trig_sync sync_man (
    .clk(clk), .rst_n(rst_n), .ce(ce), .async_in(manual_trigger_key),
    .level(man_lvl), .rise(man_rise), .fall(man_fall));
  trig_sync sync_ext (
    .clk(clk), .rst_n(rst_n), .ce(ce), .async_in(ext_trigger),
    .level(ext_lvl), .rise(ext_rise), .fall(ext_fall));
  trig_timer timer (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .enable(CHANNEL_INDEX == 2'h0),
    .period_steps(int_period_steps),
    .tick(int_tick));

  // Same-clock partner edges
  reg [4:0] peer_last_reg;
  wire [4:0] peer_now;
  wire [4:0] peer_rise;
  assign peer_now = {prev_trig_out, ch4_trig_out, ch3_trig_out,
                     ch2_trig_out, master_trigger_in};
  assign peer_rise = peer_now & ~peer_last_reg;

  // Source selection, shared by start and advance
  function sel_event;
    input [2:0] src;
    begin
      case (src)
        `SRC_SYSTEM: sel_event = sys_rise | man_rise;
        `SRC_MASTER: sel_event = peer_rise[0];
        `SRC_INTERNAL: sel_event = int_tick;
        `SRC_EXTERNAL: sel_event = ext_polarity_pos ? ext_rise
                                                     : ext_fall;
        `SRC_CH2: sel_event = (CHANNEL_INDEX == 2'h0) &
                  channel_installed[1] & peer_rise[1];
        `SRC_CH3: sel_event = (CHANNEL_INDEX == 2'h0) &
                  channel_installed[2] & peer_rise[2];
        `SRC_CH4: sel_event = (CHANNEL_INDEX == 2'h0) &
                  channel_installed[3] & peer_rise[3];
        default: sel_event = (CHANNEL_INDEX != 2'h0) & peer_rise[4];
      endcase
    end
  endfunction

  // Gate level for gated mode
  function sel_level;
    input [2:0] src;
    begin
      case (src)
        `SRC_SYSTEM: sel_level = sys_lvl | man_lvl;
        `SRC_MASTER: sel_level = peer_now[0];
        `SRC_INTERNAL: sel_level = int_tick;
        `SRC_EXTERNAL: sel_level = ext_polarity_pos ? ext_lvl : ~ext_lvl;
        `SRC_CH2: sel_level = (CHANNEL_INDEX == 2'h0) &
                  channel_installed[1] & peer_now[1];
        `SRC_CH3: sel_level = (CHANNEL_INDEX == 2'h0) &
                  channel_installed[2] & peer_now[2];
        `SRC_CH4: sel_level = (CHANNEL_INDEX == 2'h0) &
                  channel_installed[3] & peer_now[3];
        default: sel_level = (CHANNEL_INDEX != 2'h0) & peer_now[4];
      endcase
    end
  endfunction

  wire start_evt;
  wire adv_evt;
  wire gate_lvl;
  assign start_evt = sel_event(start_source);
  assign adv_evt = sel_event(advance_source);
  assign gate_lvl = sel_level(start_source);

  // Effective burst count
  reg [`COUNT_W-1:0] count_eff;
  always @* begin
    count_eff = burst_count;
    if (count_eff < `COUNT_MIN)
      count_eff = `COUNT_MIN;
    if (func_class == `FUNC_SEQUENCE && count_eff > `COUNT_SEQ_MAX)
      count_eff = `COUNT_SEQ_MAX;
  end

  reg [1:0] state_reg, state_next;
  reg [`COUNT_W-1:0] cnt_reg, cnt_next;
  reg run_next;
  reg restart_next;
  reg done_next;
  reg busy_next;

  wire is_cont;
  wire is_trig;
  wire is_gated;
  assign is_cont = (mode == `MODE_CONT) | (mode == `MODE_SWEEP_CONT);
  assign is_trig = (mode == `MODE_TRIG);
  assign is_gated = (mode == `MODE_GATED);

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    run_next = 1'b0;
    restart_next = 1'b0;
    done_next = 1'b0;
    busy_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = {`COUNT_W{1'b0}};
        if (is_cont) begin
          run_next = 1'b1;
        end else if (is_trig && start_evt) begin
          state_next = ST_RUN;
          cnt_next = count_eff;
          run_next = 1'b1;
          restart_next = 1'b1;
          busy_next = 1'b1;
        end else if (is_gated && gate_lvl) begin
          state_next = ST_RUN;
          run_next = 1'b1;
          restart_next = 1'b1;
          busy_next = 1'b1;
        end
      end
      ST_RUN: begin
        run_next = 1'b1;
        busy_next = 1'b1;
        // Start triggers during a burst are ignored
        state_next = ST_RUN;
        if (is_gated) begin
          if (!gate_lvl)
            state_next = ST_DRAIN;
        end else if (is_trig) begin
          if (cycle_end) begin
            if (cnt_reg <= `COUNT_MIN) begin
              state_next = ST_IDLE;
              run_next = 1'b0;
              busy_next = 1'b0;
              done_next = 1'b1;
            end else begin
              cnt_next = cnt_reg - `COUNT_MIN;
            end
          end
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        run_next = 1'b1;
        busy_next = 1'b1;
        if (cycle_end || !is_gated) begin
          state_next = ST_IDLE;
          run_next = 1'b0;
          busy_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sync marker position
  wire first_pts;
  wire at_first;
  reg marker_next;
  assign first_pts = (play_addr < `FIRST_POINTS);
  assign at_first = (func_class != `FUNC_STANDARD) | is_trig;
  always @* begin
    if (at_first)
      marker_next = first_pts;
    else
      marker_next = zero_cross;
  end

  reg output_on_last_reg;
  wire sweep_trig_evt;
  assign sweep_trig_evt = start_evt &
    ((mode == `MODE_SWEEP_TRIG) | (mode == `MODE_SWEEP_HOLD));

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= {`COUNT_W{1'b0}};
      peer_last_reg <= 5'h00;
      output_on_last_reg <= 1'b0;
      play_run <= 1'b0;
      play_restart <= 1'b0;
      advance_pulse <= 1'b0;
      sweep_step <= 1'b0;
      sweep_dir_up <= 1'b1;
      master_trigger_out <= 1'b0;
      wave_complete <= 1'b0;
      count_complete <= 1'b0;
      sync_marker <= 1'b0;
      sync_enable <= 1'b0;
      burst_busy <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      peer_last_reg <= peer_now;
      output_on_last_reg <= output_on;
      play_run <= run_next;
      // New function other than a sequence restarts running playback at once
      play_restart <= restart_next |
        (func_change & run_next & (func_class != `FUNC_SEQUENCE));
      advance_pulse <= adv_evt & (func_class == `FUNC_SEQUENCE);
      master_trigger_out <= (CHANNEL_INDEX == 2'h0) & int_tick;
      wave_complete <= (func_class[1]) &
        (play_addr == last_active_addr - `END_OFFSET);
      count_complete <= done_next;
      burst_busy <= busy_next;
      sync_marker <= sync_enable & marker_next & run_next;
      // Count ignored in sweep modes; each start trigger steps the sweep in triggered and hold sweep modes only
      sweep_step <= sweep_trig_evt;
      if (sweep_trig_evt && mode == `MODE_SWEEP_HOLD)
        sweep_dir_up <= ~sweep_dir_up;
      else if (mode != `MODE_SWEEP_HOLD)
        sweep_dir_up <= 1'b1;
      if (sync_set_off)
        sync_enable <= 1'b0;
      else if (sync_set_on || (output_on && !output_on_last_reg))
        sync_enable <= 1'b1;
    end
  end
endmodule

// ==== trig_burst_defines.vh ====
// Constants for the channel trigger and burst controller
`ifndef TRIG_BURST_DEFINES_VH
`define TRIG_BURST_DEFINES_VH

// Operating modes
`define MODE_CONT 3'h0
`define MODE_TRIG 3'h1
`define MODE_GATED 3'h2
`define MODE_SWEEP_CONT 3'h3
`define MODE_SWEEP_TRIG 3'h4
`define MODE_SWEEP_HOLD 3'h5

// Trigger sources
`define SRC_SYSTEM 3'h0
`define SRC_MASTER 3'h1
`define SRC_INTERNAL 3'h2
`define SRC_EXTERNAL 3'h3
`define SRC_CH2 3'h4
`define SRC_CH3 3'h5
`define SRC_CH4 3'h6
`define SRC_PREV 3'h7

// Function classes
`define FUNC_STANDARD 2'h0
`define FUNC_ZEROLESS 2'h1
`define FUNC_WAVEFORM 2'h2
`define FUNC_SEQUENCE 2'h3

// Burst counts
`define COUNT_W 20
`define COUNT_MIN 20'h0_0001
`define COUNT_MAX 20'hF_FFFF
`define COUNT_SEQ_MAX 20'h8_0000

// Sync marker width in points and end offset
`define FIRST_POINTS 24'h00_0004
`define END_OFFSET 24'h00_0008
`define ADDR_W 24

// Internal trigger timer
`define CLK_PERIOD_NS 8
`define TRIG_STEP_NS 200
`define STEP_CYCLES ((`TRIG_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PERIOD_W 36
`define PERIOD_MIN 36'h0_0000_0001
`define PERIOD_MAX 36'hB_A43B_7400

`endif

// ==== trig_sync.v ====
// Two-stage synchroniser with edge detection
`timescale 1ns/100ps
module trig_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Signal
  input wire async_in,
  output reg level,
  output wire rise,
  output wire fall
);
  reg meta_reg;
  reg last_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      level <= 1'b0;
      last_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= async_in;
      level <= meta_reg;
      last_reg <= level;
    end
  end

  assign rise = level & ~last_reg;
  assign fall = ~level & last_reg;
endmodule

// ==== trig_timer.v ====
// Internal trigger generator with a 200 ns step
`timescale 1ns/100ps
`include "trig_burst_defines.vh"
module trig_timer (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Control
  input wire enable,
  input wire [`PERIOD_W-1:0] period_steps,
  // Output
  output reg tick
);
  localparam [31:0] STEP_LAST_W = `STEP_CYCLES - 1;
  localparam [7:0] STEP_LAST = STEP_LAST_W[7:0];
  reg [7:0] pre_reg;
  reg [`PERIOD_W-1:0] step_reg;
  wire [`PERIOD_W-1:0] period_lim;

  // Clamp to the 200 ns .. 10,000 s range
  assign period_lim = (period_steps < `PERIOD_MIN) ? `PERIOD_MIN :
                      (period_steps > `PERIOD_MAX) ? `PERIOD_MAX :
                      period_steps;

  always @(posedge clk) begin
    if (!rst_n) begin
      pre_reg <= 8'h00;
      step_reg <= {`PERIOD_W{1'b0}};
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!enable) begin
        pre_reg <= 8'h00;
        step_reg <= {`PERIOD_W{1'b0}};
      end else if (pre_reg == STEP_LAST) begin
        pre_reg <= 8'h00;
        if (step_reg >= period_lim - `PERIOD_MIN) begin
          step_reg <= {`PERIOD_W{1'b0}};
          tick <= 1'b1;
        end else begin
          step_reg <= step_reg + `PERIOD_MIN;
        end
      end else begin
        pre_reg <= pre_reg + 8'h01;
      end
    end
  end
endmodule

// ==== trig_burst_chk.sv ====
// Port checks for the trigger and burst controller
`timescale 1ns/100ps
`include "trig_burst_defines.vh"
module trig_burst_chk (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Inputs watched
  input wire [2:0] mode,
  input wire output_on,
  input wire sync_set_off,
  input wire [`ADDR_W-1:0] play_addr,
  input wire [`ADDR_W-1:0] last_active_addr,
  input wire cycle_end,
  // Outputs watched
  input wire play_run,
  input wire play_restart,
  input wire count_complete,
  input wire wave_complete,
  input wire sync_enable,
  input wire burst_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    $rose(play_run) && mode == `MODE_TRIG;
  endsequence
  sequence s_cont;
    (mode == `MODE_CONT && ce) [*4];
  endsequence
  property p_start;
    s_start |-> play_restart && burst_busy;
  endproperty
  property p_busy;
    mode == `MODE_TRIG && burst_busy |-> play_run;
  endproperty
  property p_cc;
    count_complete |-> !play_run && !burst_busy && $past(cycle_end);
  endproperty
  property p_cc_pulse;
    count_complete |=> !count_complete;
  endproperty
  property p_restart;
    play_restart |=> !play_restart && play_run;
  endproperty
  property p_cont;
    s_cont |-> play_run;
  endproperty
  property p_wc;
    wave_complete |-> $past(play_addr == last_active_addr - `END_OFFSET);
  endproperty
  property p_sync_on;
    $rose(output_on) && !sync_set_off |-> ##[1:2] sync_enable;
  endproperty
  property p_sync_off;
    sync_set_off |=> !sync_enable;
  endproperty
  a_start: assert property (p_start)
    else $error("burst start without restart");
  a_busy: assert property (p_busy)
    else $error("busy without run");
  a_cc: assert property (p_cc)
    else $error("count complete out of place");
  a_cc_pulse: assert property (p_cc_pulse)
    else $error("count complete too long");
  a_restart: assert property (p_restart)
    else $error("restart pulse wrong");
  a_cont: assert property (p_cont)
    else $error("continuous run stopped");
  a_wc: assert property (p_wc)
    else $error("wave complete at wrong address");
  a_sync_on: assert property (p_sync_on)
    else $error("sync enable not set");
  a_sync_off: assert property (p_sync_off)
    else $error("sync enable not cleared");
endmodule
bind channel_trigger_burst_control trig_burst_chk u_chk (.*);

// ==== play_engine_model.sv ====
// Playback engine stand-in walking a short waveform
`timescale 1ns/100ps
module play_engine_model #(
  parameter [23:0] LAST = 24'h00_000F
) (
  // Clock
  input wire clk,
  // Control
  input wire play_run,
  input wire play_restart,
  // Status
  output reg [23:0] play_addr,
  output wire [23:0] last_active_addr,
  output reg cycle_end,
  output wire zero_cross
);
  assign last_active_addr = LAST;
  // Mid cycle stands for the zero crossing
  assign zero_cross = (play_addr == (LAST >> 1));
  always @(posedge clk) begin
    cycle_end <= play_run && !play_restart && play_addr == LAST;
    if (play_restart || !play_run || play_addr == LAST)
      play_addr <= 24'h00_0000;
    else
      play_addr <= play_addr + 24'h00_0001;
  end
endmodule

// ==== testbench.sv ====
// Testbench for the channel trigger and burst controller
`timescale 1ns/100ps
`include "trig_burst_defines.vh"
module testbench;
  reg clk, rst_n, ce, func_change, ext_polarity_pos, output_on;
  reg sync_set_on, sync_set_off, system_trigger, manual_trigger_key;
  reg ext_trigger, ch2_trig_out, prev_ce;
  reg [2:0] mode, start_source, advance_source;
  reg [1:0] func_class;
  reg [19:0] burst_count;
  reg [3:1] channel_installed;
  wire [23:0] play_addr, last_active_addr;
  wire cycle_end, zero_cross, play_run, play_restart, master_trig;
  wire sync_enable, burst_busy, sweep_dir_up;
  wire sync_marker, advance_pulse, sweep_step;
  integer miscompares, n_checks, i, n;
  channel_trigger_burst_control dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .mode(mode), .start_source(start_source),
    .advance_source(advance_source),
    .func_class(func_class), .func_change(func_change),
    .burst_count(burst_count), .int_period_steps(36'h0_0000_0002),
    .ext_polarity_pos(ext_polarity_pos),
    .channel_installed(channel_installed), .output_on(output_on),
    .sync_set_on(sync_set_on), .sync_set_off(sync_set_off),
    .system_trigger(system_trigger),
    .manual_trigger_key(manual_trigger_key), .ext_trigger(ext_trigger),
    .master_trigger_in(master_trig), .ch2_trig_out(ch2_trig_out),
    .ch3_trig_out(1'b0), .ch4_trig_out(1'b0), .prev_trig_out(1'b0),
    .play_addr(play_addr), .last_active_addr(last_active_addr),
    .cycle_end(cycle_end), .zero_cross(zero_cross),
    .play_run(play_run), .play_restart(play_restart),
    .advance_pulse(advance_pulse), .sweep_step(sweep_step),
    .sweep_dir_up(sweep_dir_up),
    .master_trigger_out(master_trig), .wave_complete(),
    .count_complete(), .sync_marker(sync_marker),
    .sync_enable(sync_enable),
    .burst_busy(burst_busy));
  play_engine_model eng (.clk(clk), .play_run(play_run),
    .play_restart(play_restart), .play_addr(play_addr),
    .last_active_addr(last_active_addr), .cycle_end(cycle_end),
    .zero_cross(zero_cross));
  task step(input integer c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task chk(input [19:0] g, input [19:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Waits for busy (s=0) or run (s=1)
  task wait_hi(input s);
    for (i = 0; i < 200 && (s ? play_run : burst_busy) !== 1'b1; i = i + 1)
      step(1);
    if (i == 200) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  endtask
  // Waits for the engine to reach address a
  task wait_addr(input [23:0] a);
    for (i = 0; i < 40 && play_addr !== a; i = i + 1)
      step(1);
    if (i == 40) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  endtask
  // Counts cycles of one burst, retriggering midway
  task burst(input [19:0] exp);
    wait_hi(0);
    n = 0;
    for (i = 0; i < 400 && burst_busy === 1'b1; i = i + 1) begin
      system_trigger = (i >= 3 && i < 9);
      if (cycle_end === 1'b1)
        n = n + 1;
      step(1);
    end
    system_trigger = 0;
    if (i == 400) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
    chk(n, exp);
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    miscompares = 0;
    n_checks = 0;
    rst_n = 0;
    ce = 1;
    func_change = 0;
    ext_polarity_pos = 1;
    output_on = 0;
    sync_set_on = 0;
    sync_set_off = 0;
    system_trigger = 0;
    manual_trigger_key = 0;
    ext_trigger = 0;
    ch2_trig_out = 0;
    mode = `MODE_TRIG;
    start_source = `SRC_SYSTEM;
    advance_source = `SRC_SYSTEM;
    func_class = `FUNC_WAVEFORM;
    burst_count = 20'h0_0003;
    channel_installed = 3'h0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    chk(sweep_dir_up, 1);
    chk(play_run, 0);
    system_trigger = 1;
    step(4);
    system_trigger = 0;
    burst(3);
    step(8);
    chk(burst_busy, 0);
    burst_count = 20'h0_0001;
    manual_trigger_key = 1;
    step(4);
    manual_trigger_key = 0;
    burst(1);
    start_source = `SRC_EXTERNAL;
    ext_polarity_pos = 0;
    ext_trigger = 1;
    step(8);
    chk(burst_busy, 0);
    ext_trigger = 0;
    burst(1);
    start_source = `SRC_CH2;
    ch2_trig_out = 1;
    step(2);
    ch2_trig_out = 0;
    step(4);
    chk(burst_busy, 0);
    channel_installed = 3'h1;
    ch2_trig_out = 1;
    step(2);
    ch2_trig_out = 0;
    burst(1);
    start_source = `SRC_MASTER;
    burst_count = 20'h0_0002;
    burst(2);
    start_source = `SRC_EXTERNAL;
    mode = `MODE_CONT;
    step(6);
    chk(play_run, 1);
    output_on = 1;
    step(3);
    chk(sync_enable, 1);
    sync_set_off = 1;
    step(1);
    sync_set_off = 0;
    step(2);
    chk(sync_enable, 0);
    sync_set_on = 1;
    step(1);
    sync_set_on = 0;
    step(2);
    chk(sync_enable, 1);
    mode = `MODE_GATED;
    ext_polarity_pos = 1;
    step(40);
    chk(play_run, 0);
    ext_trigger = 1;
    wait_hi(1);
    step(20);
    chk(play_run, 1);
    ext_trigger = 0;
    prev_ce = 0;
    for (i = 0; i < 60 && play_run === 1'b1; i = i + 1) begin
      prev_ce = cycle_end;
      step(1);
    end
    if (i == 60) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
    chk(prev_ce, 1);
    mode = `MODE_CONT;
    func_change = 1;
    step(1);
    func_change = 0;
    chk(play_restart, 1);
    wait_addr(24'h00_0002);
    step(1);
    chk(sync_marker, 1);
    wait_addr(24'h00_0007);
    step(1);
    chk(sync_marker, 0);
    func_class = `FUNC_STANDARD;
    wait_addr(24'h00_0007);
    step(1);
    chk(sync_marker, 1);
    wait_addr(24'h00_0002);
    step(1);
    chk(sync_marker, 0);
    func_class = `FUNC_ZEROLESS;
    wait_addr(24'h00_0002);
    step(1);
    chk(sync_marker, 1);
    wait_addr(24'h00_0007);
    step(1);
    chk(sync_marker, 0);
    // Triggered standard function marks the first points
    func_class = `FUNC_STANDARD;
    mode = `MODE_TRIG;
    start_source = `SRC_SYSTEM;
    system_trigger = 1;
    step(4);
    system_trigger = 0;
    wait_addr(24'h00_0002);
    step(1);
    chk(sync_marker, 1);
    wait_addr(24'h00_0007);
    step(1);
    chk(sync_marker, 0);
    step(30);
    chk(burst_busy, 0);
    func_class = `FUNC_SEQUENCE;
    advance_source = `SRC_EXTERNAL;
    ext_trigger = 1;
    step(3);
    chk(advance_pulse, 1);
    step(1);
    chk(advance_pulse, 0);
    chk(burst_busy, 0);
    ext_trigger = 0;
    mode = `MODE_SWEEP_HOLD;
    system_trigger = 1;
    step(3);
    chk(sweep_step, 1);
    chk(sweep_dir_up, 0);
    system_trigger = 0;
    step(4);
    system_trigger = 1;
    step(3);
    chk(sweep_dir_up, 1);
    system_trigger = 0;
    tally_and_finish;
  end
endmodule
